// File: common/tmc_consts.vh
// Operation
// RULE1: one strap input picks whether management answers as PHY-side or DTE-side device.
// RULE2: management uses the clock line as reference and one shared two-way data line.
// RULE3: five-bit strapped port address; only frames carrying it are answered.
// RULE4: coding select high enables encoder and decoder; low bypasses both.
// RULE5: direction pair: 00 full, 01 transmit only, 10 receive only, 11 repeater.
// RULE6: standby enable low holds low power; high runs normally.
// RULE7: per lane, loopback enable high loops serial transmit back to receive.
// RULE8: lane status output selectable by management: signal lost, comma, pattern status.
// RULE9: default lane status shows I/O standard: 1 HSTL, 0 SSTL_2, SSTL_2 default.
// RULE10: pattern test enable inserts generator and checker into every lane.
// RULE11: pattern pass shows on status outputs only once management selects it.
// RULE12: lane sync high clocks all lanes from lane A transmit and receive clocks.
// RULE13: buffer reset low recenters skew buffers and FIFOs, clears management flags.
// RULE14: align enable high turns on comma detection and byte alignment everywhere.
// RULE15: the system keeps the factory test input low or unconnected.
// RULE16: lane sync low makes each lane latch with its own transmit clock.
// RULE17: in lane sync mode, lanes B to D transmit clocks are ignored.
// RULE18: coding and lane sync both high give extender sublayer transceiver mode.
// RULE19: control inputs are synchronised; address straps are frozen after reset.
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH
`define TMC_LANES 4
`define TMC_OFF_CTRL 32'h0000_0000
`define TMC_OFF_MODE 32'h0000_0004
`define TMC_OFF_FLAGS 32'h0000_0008
`define TMC_OFF_STRAP 32'h0000_000C
`define TMC_RESP_OKAY 2'h0
`define TMC_RESP_SLVERR 2'h2
`define TMC_CTRL_FN_LSB 0
`define TMC_CTRL_HSTL_BIT 2
`define TMC_FLAGS_COMMA_LSB 4
`define TMC_FN_IOSTD 2'h0
`define TMC_FN_LOST 2'h1
`define TMC_FN_COMMA 2'h2
`define TMC_FN_PATTERN 2'h3
`define TMC_FN_RST 2'h0
`define TMC_HSTL_RST 1'b0
`define TMC_DIR_FULL 2'h0
`define TMC_DIR_TX 2'h1
`define TMC_DIR_RX 2'h2
`define TMC_DIR_RPT 2'h3
`define TMC_MMD_PHY_XS 5'h04
`define TMC_MMD_DTE_XS 5'h05
`define TMC_MDIO_REG_SEL 16'h8000
`define TMC_MDIO_REG_FLAGS 16'h8001
`define TMC_PRE_LEN 6'h20
`define TMC_HDR_LAST 6'h0C
`define TMC_DAT_LAST 6'h0F
`define TMC_OP_ADDR 2'h0
`define TMC_OP_WRITE 2'h1
`define TMC_OP_RDINC 2'h2
`define TMC_STRAP_CYC 2'h3
`endif

// File: logic/tmc_sync.v
`timescale 1ns/10ps
`default_nettype none
module tmc_sync #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_ce,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (i_ce) begin
          meta_q <= i_d[g]; // RULE19
          sync_q <= meta_q;
        end
      end
      assign o_q[g] = sync_q;
    end
  endgenerate
endmodule
`default_nettype wire

// File: logic/tmc_mdio.v
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_mdio (
  input wire i_clk,
  input wire i_nrst,
  input wire i_ce,
  input wire i_mdc,
  input wire i_mdio,
  input wire [4:0] i_port_addr,
  input wire i_role,
  input wire [15:0] i_rd_data,
  output reg [15:0] o_reg_addr,
  output reg o_wr_stb,
  output reg [15:0] o_wr_data,
  output reg o_mdio_out,
  output reg o_mdio_oe
);
  localparam S_PRE = 2'h0;
  localparam S_HDR = 2'h1;
  localparam S_TA = 2'h2;
  localparam S_DAT = 2'h3;
  reg mdc_q;
  reg [1:0] st_q;
  reg [5:0] cnt_q;
  reg [11:0] hdr_q;
  reg [15:0] dat_q;
  reg hit_q;
  reg [1:0] op_q;
  wire rise = i_mdc & ~mdc_q;
  wire [12:0] full = {hdr_q, i_mdio};
  wire [4:0] mmd = i_role ? `TMC_MMD_DTE_XS : `TMC_MMD_PHY_XS; // RULE1
  wire rd = hit_q & op_q[1];
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mdc_q <= 1'b0;
      st_q <= S_PRE;
      cnt_q <= 6'h00;
      hdr_q <= 12'h000;
      dat_q <= 16'h0000;
      hit_q <= 1'b0;
      op_q <= 2'h0;
      o_reg_addr <= 16'h0000;
      o_wr_stb <= 1'b0;
      o_wr_data <= 16'h0000;
      o_mdio_out <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else if (i_ce) begin
      mdc_q <= i_mdc;
      o_wr_stb <= 1'b0;
      // all bits sampled on the management clock rising edge
      if (rise) begin // RULE2
        case (st_q)
          S_PRE: begin
            if (i_mdio) begin
              if (cnt_q != `TMC_PRE_LEN)
                cnt_q <= cnt_q + 6'h01;
            end else begin
              if (cnt_q == `TMC_PRE_LEN)
                st_q <= S_HDR;
              cnt_q <= 6'h00;
            end
          end
          S_HDR: begin
            hdr_q <= full[11:0];
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == `TMC_HDR_LAST) begin
              hit_q <= ~full[12] & (full[9:5] == i_port_addr) &
                (full[4:0] == mmd); // RULE3
              op_q <= full[11:10];
              st_q <= S_TA;
              cnt_q <= 6'h00;
            end
          end
          S_TA: begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h00) begin
              o_mdio_oe <= rd;
              o_mdio_out <= 1'b0;
            end else begin
              o_mdio_out <= rd & i_rd_data[15];
              dat_q <= {i_rd_data[14:0], 1'b0};
              st_q <= S_DAT;
              cnt_q <= 6'h00;
            end
          end
          S_DAT: begin
            cnt_q <= cnt_q + 6'h01;
            if (rd) begin
              o_mdio_out <= dat_q[15];
              dat_q <= {dat_q[14:0], 1'b0};
            end else
              dat_q <= {dat_q[14:0], i_mdio};
            if (cnt_q == `TMC_DAT_LAST) begin
              o_mdio_oe <= 1'b0;
              o_mdio_out <= 1'b0;
              st_q <= S_PRE;
              cnt_q <= 6'h00;
              if (hit_q && op_q == `TMC_OP_ADDR)
                o_reg_addr <= {dat_q[14:0], i_mdio};
              if (hit_q && op_q == `TMC_OP_RDINC)
                o_reg_addr <= o_reg_addr + 16'h0001;
              if (hit_q && op_q == `TMC_OP_WRITE) begin
                o_wr_stb <= 1'b1;
                o_wr_data <= {dat_q[14:0], i_mdio};
              end
            end
          end
          default: begin
            st_q <= S_PRE;
            cnt_q <= 6'h00;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/tmc_top.v
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_top (
  input wire i_clk,
  input wire i_nrst,
  input wire i_ce,
  input wire i_xs_role_select,
  input wire [4:0] i_phy_port_address,
  input wire i_coding_select,
  input wire i_direction_config_lo,
  input wire i_direction_config_hi,
  input wire i_standby_en,
  input wire [3:0] i_serial_loopback_en,
  input wire i_pattern_test_en,
  input wire i_lane_sync_select,
  input wire i_buffer_reset_n,
  input wire i_align_enable,
  input wire i_factory_test_en,
  input wire [3:0] i_signal_lost,
  input wire [3:0] i_comma_seen,
  input wire [3:0] i_pattern_check_pass,
  input wire i_mdc,
  input wire i_mdio_in,
  output reg o_mdio_out,
  output reg o_mdio_oe,
  output reg o_encoder_en,
  output reg o_decoder_en,
  output reg o_tx_en,
  output reg o_rx_en,
  output reg o_repeater_en,
  output reg o_low_power,
  output reg [3:0] o_loopback_en,
  output reg o_pattern_gen_en,
  output reg o_pattern_chk_en,
  output reg o_lane_sync_mode,
  output reg [3:0] o_lane_clk_from_a,
  output reg o_xgxs_mode,
  output reg o_buffer_recenter,
  output reg o_align_en,
  output reg [3:0] o_lane_status_out,
  input wire [31:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [31:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready
);
  // control pins
  wire [18:0] pins_s;
  tmc_sync #(.W(19)) u_pins (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_d({i_coding_select, i_direction_config_hi, i_direction_config_lo,
      i_standby_en, i_serial_loopback_en, i_pattern_test_en,
      i_lane_sync_select, i_buffer_reset_n, i_align_enable,
      i_factory_test_en, i_xs_role_select, i_phy_port_address}),
    .o_q(pins_s)
  );
  wire code_s = pins_s[18];
  wire [1:0] dir_s = pins_s[17:16];
  wire stby_s = pins_s[15];
  wire [3:0] lpen_s = pins_s[14:11];
  wire ptest_s = pins_s[10];
  wire lsync_s = pins_s[9];
  wire bufrst_n_s = pins_s[8];
  wire align_s = pins_s[7];
  wire ftest_s = pins_s[6];
  wire role_s = pins_s[5];
  wire [4:0] padr_s = pins_s[4:0];
  // lane status and management line
  wire [13:0] stat_s;
  tmc_sync #(.W(14)) u_stat (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_d({i_mdc, i_mdio_in, i_signal_lost, i_comma_seen,
      i_pattern_check_pass}),
    .o_q(stat_s)
  );
  wire mdc_s = stat_s[13];
  wire mdio_s = stat_s[12];
  wire [3:0] lost_s = stat_s[11:8];
  wire [3:0] comma_s = stat_s[7:4];
  wire [3:0] pass_s = stat_s[3:0];

  // straps sampled only just after release, so late glitches cannot
  // move the device to another address
  reg [1:0] strap_cnt_q;
  reg [4:0] padr_q;
  reg role_q;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_cnt_q <= 2'h0;
      padr_q <= 5'h00;
      role_q <= 1'b0;
    end else if (i_ce && strap_cnt_q != `TMC_STRAP_CYC) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      padr_q <= padr_s; // RULE19 RULE3
      role_q <= role_s; // RULE1
    end
  end

  reg [1:0] fn_q;
  reg hstl_q;
  reg [3:0] lost_q;
  reg [3:0] comma_q;
  wire [15:0] mreg_addr;
  wire mwr_stb;
  wire [15:0] mwr_data;
  wire mdio_out;
  wire mdio_oe;
  reg [15:0] mrd_data;
  always @* begin
    mrd_data = 16'h0000;
    if (mreg_addr == `TMC_MDIO_REG_SEL)
      mrd_data = {13'h0000, hstl_q, fn_q};
    else if (mreg_addr == `TMC_MDIO_REG_FLAGS)
      mrd_data = {8'h00, comma_q, lost_q};
  end
  tmc_mdio u_mdio (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_mdc(mdc_s),
    .i_mdio(mdio_s),
    .i_port_addr(padr_q),
    .i_role(role_q),
    .i_rd_data(mrd_data),
    .o_reg_addr(mreg_addr),
    .o_wr_stb(mwr_stb),
    .o_wr_data(mwr_data),
    .o_mdio_out(mdio_out),
    .o_mdio_oe(mdio_oe)
  );

  // bus write path: address and data caught in either order
  reg aw_have_q;
  reg w_have_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire wr_go = aw_have_q & w_have_q & ~o_s_axi_bvalid;
  wire wr_ctrl = wr_go & (awaddr_q == `TMC_OFF_CTRL) & wstrb_q[0];
  wire wr_flags = wr_go & (awaddr_q == `TMC_OFF_FLAGS) & wstrb_q[0];
  wire wr_ok = (awaddr_q == `TMC_OFF_CTRL) |
    (awaddr_q == `TMC_OFF_FLAGS);
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `TMC_RESP_OKAY;
    end else if (i_ce) begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        awaddr_q <= i_s_axi_awaddr;
        aw_have_q <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
        w_have_q <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // function select; a bus write wins over a same-cycle management write
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fn_q <= `TMC_FN_RST; // RULE9
      hstl_q <= `TMC_HSTL_RST;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        fn_q <= wdata_q[`TMC_CTRL_FN_LSB+1:`TMC_CTRL_FN_LSB]; // RULE8
        hstl_q <= wdata_q[`TMC_CTRL_HSTL_BIT];
      end else if (mwr_stb && mreg_addr == `TMC_MDIO_REG_SEL) begin
        fn_q <= mwr_data[1:0]; // RULE8
        hstl_q <= mwr_data[2];
      end
    end
  end

  // sticky flags: a new event beats a software clear
  wire [3:0] lost_clr = wr_flags ? wdata_q[3:0] : 4'h0;
  wire [3:0] comma_clr = wr_flags ?
    wdata_q[`TMC_FLAGS_COMMA_LSB+3:`TMC_FLAGS_COMMA_LSB] : 4'h0;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lost_q <= 4'h0;
      comma_q <= 4'h0;
    end else if (i_ce) begin
      if (!bufrst_n_s) begin
        lost_q <= 4'h0; // RULE13
        comma_q <= 4'h0;
      end else begin
        lost_q <= (lost_q & ~lost_clr) | lost_s;
        comma_q <= (comma_q & ~comma_clr) | comma_s;
      end
    end
  end

  // bus read path, one cycle after the address is taken
  reg [31:0] rd_d;
  reg rd_ok;
  always @* begin
    rd_d = 32'h0000_0000;
    rd_ok = 1'b1;
    case (i_s_axi_araddr)
      `TMC_OFF_CTRL: rd_d = {29'h0000_0000, hstl_q, fn_q};
      `TMC_OFF_MODE: rd_d = {18'h0_0000, ftest_s, o_xgxs_mode,
        o_lane_sync_mode, o_align_en, o_pattern_gen_en, o_low_power,
        o_buffer_recenter, o_loopback_en, dir_s, code_s};
      `TMC_OFF_FLAGS: rd_d = {24'h00_0000, comma_q, lost_q};
      `TMC_OFF_STRAP: rd_d = {26'h000_0000, role_q, padr_q};
      default: rd_ok = 1'b0;
    endcase
  end
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `TMC_RESP_OKAY;
    end else if (i_ce) begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_d;
        o_s_axi_rresp <= rd_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // per-lane status pin multiplexer
  wire [3:0] lane_d;
  genvar g;
  generate
    for (g = 0; g < `TMC_LANES; g = g + 1) begin : g_lane
      assign lane_d[g] = (fn_q == `TMC_FN_LOST) ? lost_s[g] : // RULE8
        (fn_q == `TMC_FN_COMMA) ? comma_s[g] :
        (fn_q == `TMC_FN_PATTERN) ? (pass_s[g] & ptest_s) : // RULE11
        hstl_q; // RULE9
    end
  endgenerate

  // mode decode; every output registered
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mdio_out <= 1'b0;
      o_mdio_oe <= 1'b0;
      o_encoder_en <= 1'b0;
      o_decoder_en <= 1'b0;
      o_tx_en <= 1'b0;
      o_rx_en <= 1'b0;
      o_repeater_en <= 1'b0;
      o_low_power <= 1'b1;
      o_loopback_en <= 4'h0;
      o_pattern_gen_en <= 1'b0;
      o_pattern_chk_en <= 1'b0;
      o_lane_sync_mode <= 1'b0;
      o_lane_clk_from_a <= 4'h1;
      o_xgxs_mode <= 1'b0;
      o_buffer_recenter <= 1'b1;
      o_align_en <= 1'b0;
      o_lane_status_out <= 4'h0;
    end else if (i_ce) begin
      o_mdio_out <= mdio_out; // RULE2
      o_mdio_oe <= mdio_oe;
      o_encoder_en <= code_s; // RULE4
      o_decoder_en <= code_s;
      o_tx_en <= (dir_s == `TMC_DIR_FULL) | (dir_s == `TMC_DIR_TX); // RULE5
      o_rx_en <= (dir_s == `TMC_DIR_FULL) | (dir_s == `TMC_DIR_RX);
      o_repeater_en <= (dir_s == `TMC_DIR_RPT);
      o_low_power <= ~stby_s; // RULE6
      o_loopback_en <= lpen_s; // RULE7
      o_pattern_gen_en <= ptest_s; // RULE10
      o_pattern_chk_en <= ptest_s;
      o_lane_sync_mode <= lsync_s; // RULE12
      // lane A always uses its own clock; B to D follow A in sync mode
      o_lane_clk_from_a <= lsync_s ? 4'hF : 4'h1; // RULE16 RULE17
      o_xgxs_mode <= code_s & lsync_s; // RULE18
      o_buffer_recenter <= ~bufrst_n_s; // RULE13
      o_align_en <= align_s; // RULE14
      o_lane_status_out <= lane_d;
    end
  end
endmodule
`default_nettype wire

// File: dv/tmc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module tmc_top_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_coding_select,
  input wire logic i_direction_config_lo,
  input wire logic i_direction_config_hi,
  input wire logic i_standby_en,
  input wire logic [3:0] i_serial_loopback_en,
  input wire logic i_pattern_test_en,
  input wire logic i_lane_sync_select,
  input wire logic i_buffer_reset_n,
  input wire logic o_encoder_en,
  input wire logic o_decoder_en,
  input wire logic o_tx_en,
  input wire logic o_rx_en,
  input wire logic o_repeater_en,
  input wire logic o_low_power,
  input wire logic [3:0] o_loopback_en,
  input wire logic o_pattern_gen_en,
  input wire logic o_pattern_chk_en,
  input wire logic [3:0] o_lane_clk_from_a,
  input wire logic o_xgxs_mode,
  input wire logic o_buffer_recenter,
  input wire logic o_mdio_out,
  input wire logic o_mdio_oe
);
  // pins are only comparable once the three-stage pipe holds post-reset values
  logic [2:0] cnt_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) cnt_q <= 3'h0;
    else if (cnt_q != 3'h4) cnt_q <= cnt_q + 3'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_coding;
    cnt_q == 3'h4 |-> o_encoder_en == $past(i_coding_select, 3)
      && o_decoder_en == $past(i_coding_select, 3);
  endproperty
  a_coding: assert property (p_coding) else $error("coding enable wrong");
  property p_dir;
    cnt_q == 3'h4 |-> o_repeater_en == ($past(i_direction_config_hi, 3)
      && $past(i_direction_config_lo, 3))
      && o_tx_en == !$past(i_direction_config_hi, 3)
      && o_rx_en == !$past(i_direction_config_lo, 3);
  endproperty
  a_dir: assert property (p_dir) else $error("direction decode wrong");
  property p_standby;
    cnt_q == 3'h4 |-> o_low_power == !$past(i_standby_en, 3);
  endproperty
  a_standby: assert property (p_standby) else $error("low power wrong");
  property p_loop;
    cnt_q == 3'h4 |-> o_loopback_en == $past(i_serial_loopback_en, 3);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback wrong");
  property p_pattern;
    cnt_q == 3'h4 |-> o_pattern_gen_en == $past(i_pattern_test_en, 3)
      && o_pattern_chk_en == $past(i_pattern_test_en, 3);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern wrong");
  property p_sync;
    cnt_q == 3'h4 |-> o_lane_clk_from_a
      == ($past(i_lane_sync_select, 3) ? 4'hF : 4'h1);
  endproperty
  a_sync: assert property (p_sync) else $error("lane clock wrong");
  property p_xgxs;
    cnt_q == 3'h4 |-> o_xgxs_mode
      == ($past(i_coding_select, 3) && $past(i_lane_sync_select, 3));
  endproperty
  a_xgxs: assert property (p_xgxs) else $error("extender mode wrong");
  property p_recenter;
    cnt_q == 3'h4 |-> o_buffer_recenter == !$past(i_buffer_reset_n, 3);
  endproperty
  a_recenter: assert property (p_recenter) else $error("recenter wrong");
  property p_turn;
    $rose(o_mdio_oe) |-> !o_mdio_out;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround not zero");
endmodule
`default_nettype wire

// File: dv/tmc_station.sv
`timescale 1ns/10ps
`default_nettype none
module tmc_station (
  input wire logic i_clk,
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe
);
  // clock rests low between frames; ten core cycles per bit keeps margin
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] da, input logic [15:0] d,
                       output logic [15:0] rd);
    logic [63:0] f;
    integer i;
    f = {32'hFFFFFFFF, 2'b00, op, pa, da, 2'b10, d};
    rd = 16'h0;
    @(posedge i_clk);
    for (i = 63; i >= 0; i--) begin
      o_mdio_oe <= !(op[1] && i < 18);
      o_mdio <= f[i];
      repeat (5) @(posedge i_clk);
      o_mdc <= 1'b1;
      if (i < 16) rd[i] = i_mdio;
      repeat (5) @(posedge i_clk);
      o_mdc <= 1'b0;
    end
    o_mdio_oe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/tmc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_top_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic role, code, dlo, dhi, stby, pat, sync, brn, aln;
  logic [4:0] pad, dv;
  logic [3:0] lpe, lost, cma, pas, e, stb;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, r;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  wire awr, wr, bv, arr, rv, mdc, sdo, soe, mout, moe, mdio;
  wire [1:0] brs, rrs;
  wire [31:0] rdt;
  wire [3:0] lso;
  logic [33:0] expq[$];
  logic [1:0] rs;
  logic [15:0] rd;
  integer num_errors = 0, n_compared = 0, i;
  always #2.5 clk = ~clk;
  // the line has a pull-up, so a released line reads high
  assign mdio = moe ? mout : (soe ? sdo : 1'b1);
  tmc_top u_dut(.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
    .i_xs_role_select(role), .i_phy_port_address(pad),
    .i_coding_select(code), .i_direction_config_lo(dlo),
    .i_direction_config_hi(dhi), .i_standby_en(stby),
    .i_serial_loopback_en(lpe), .i_pattern_test_en(pat),
    .i_lane_sync_select(sync), .i_buffer_reset_n(brn),
    .i_align_enable(aln), .i_factory_test_en(1'b0),
    .i_signal_lost(lost), .i_comma_seen(cma), .i_pattern_check_pass(pas),
    .i_mdc(mdc), .i_mdio_in(mdio), .o_mdio_out(mout), .o_mdio_oe(moe),
    .o_encoder_en(), .o_decoder_en(), .o_tx_en(), .o_rx_en(),
    .o_repeater_en(), .o_low_power(), .o_loopback_en(),
    .o_pattern_gen_en(), .o_pattern_chk_en(), .o_lane_sync_mode(),
    .o_lane_clk_from_a(), .o_xgxs_mode(), .o_buffer_recenter(),
    .o_align_en(), .o_lane_status_out(lso),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(stb), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr), .o_s_axi_bresp(brs), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bre), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdt), .o_s_axi_rresp(rrs),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre));
  tmc_station u_sta(.i_clk(clk), .i_mdio(mdio), .o_mdc(mdc), .o_mdio(sdo),
    .o_mdio_oe(soe));
  task automatic check(input string nm, input logic [33:0] seen,
                       input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task tmo(input integer t);
    if (t >= 200) begin
      num_errors++;
      results;
    end
  endtask
  task axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] q);
    integer t;
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awaddr <= a;
    awv <= 1;
    wdata <= d;
    wv <= 1;
    bre <= 1;
    for (t = 0; t < 200 && !(ad && wd); t++) begin
      @(posedge clk);
      if (awv && awr) begin
        ad = 1;
        awv <= 0;
      end
      if (wv && wr) begin
        wd = 1;
        wv <= 0;
      end
    end
    tmo(t);
    for (t = 0; t < 200; t++) begin
      @(posedge clk);
      if (bv) break;
    end
    q = brs;
    bre <= 0;
    tmo(t);
  endtask
  task axr(input logic [31:0] a, input logic [33:0] x);
    integer t;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rre <= 1;
    expq.push_back(x);
    for (t = 0; t < 200; t++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) break;
    end
    rre <= 0;
    tmo(t);
  endtask
  // read results are judged where they appear, against the oldest note
  always @(posedge clk) begin
    if (rv && rre) check("rdata", {rrs, rdt}, expq.pop_front());
  end
  function automatic logic [33:0] mexp();
    return {20'h0, 1'b0, code & sync, sync, aln, pat, !stby, !brn, lpe,
            dhi, dlo, code};
  endfunction
  initial begin
    void'($urandom(30460));
    role = 1'($urandom);
    pad = 5'($urandom);
    {code, dlo, dhi, stby, pat, sync, brn, aln} = 8'h0;
    {lpe, lost, cma, pas} = 16'h0;
    stb = 4'hF;
    repeat (5) @(posedge clk);
    nrst <= 1;
    // straps are captured on the first three edges after release; the third one is kept
    repeat (3) @(posedge clk);
    axr(`TMC_OFF_STRAP, {28'h0, role, pad});
    axr(`TMC_OFF_CTRL, 34'h0);
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      r[9:8] = {i[2], i[0]};
      @(posedge clk);
      {code, sync, stby, pat, brn, aln, lpe} <= r[9:0];
      {dhi, dlo} <= i[1:0];
      repeat (4) @(posedge clk);
      axr(`TMC_OFF_MODE, mexp());
    end
    axr(32'h10, {`TMC_RESP_SLVERR, 32'h0});
    @(posedge clk);
    lost <= 4'($urandom);
    cma <= 4'($urandom);
    pas <= 4'($urandom);
    brn <= 1;
    for (i = 0; i < 8; i++) begin
      pat <= i[2];
      axw(`TMC_OFF_CTRL, {29'h0, i[2:0]}, rs);
      repeat (6) @(posedge clk);
      e = i[1:0] == 0 ? {4{i[2]}} : i[1:0] == 1 ? lost : i[1:0] == 2 ? cma
        : pas & {4{pat}};
      check("lane_status", {30'h0, lso}, {30'h0, e});
    end
    stb <= 4'hE;
    axw(`TMC_OFF_CTRL, 32'h0, rs);
    stb <= 4'hF;
    axr(`TMC_OFF_CTRL, 34'h7);
    lost <= 0;
    cma <= 0;
    repeat (4) @(posedge clk);
    axw(`TMC_OFF_FLAGS, 32'hFF, rs);
    check("bresp", {32'h0, rs}, {32'h0, `TMC_RESP_OKAY});
    axr(`TMC_OFF_FLAGS, 34'h0);
    lost <= 4'hA;
    cma <= 4'h3;
    repeat (4) @(posedge clk);
    lost <= 0;
    cma <= 0;
    repeat (4) @(posedge clk);
    axr(`TMC_OFF_FLAGS, 34'h3A);
    brn <= 0;
    repeat (4) @(posedge clk);
    axr(`TMC_OFF_FLAGS, 34'h0);
    dv = role ? `TMC_MMD_DTE_XS : `TMC_MMD_PHY_XS;
    u_sta.frame(`TMC_OP_ADDR, pad, dv, `TMC_MDIO_REG_SEL, rd);
    u_sta.frame(`TMC_OP_WRITE, pad, dv, 16'h0001, rd);
    u_sta.frame(2'h3, pad, dv, 16'h0, rd);
    check("mdio_read", {18'h0, rd}, 34'h1);
    lost <= 4'($urandom);
    repeat (6) @(posedge clk);
    check("lane_status", {30'h0, lso}, {30'h0, lost});
    u_sta.frame(`TMC_OP_WRITE, pad ^ 5'h01, dv, 16'h0002, rd);
    u_sta.frame(`TMC_OP_WRITE, pad, dv ^ 5'h01, 16'h0003, rd);
    u_sta.frame(2'h3, pad ^ 5'h01, dv, 16'h0, rd);
    check("mdio_foreign", {18'h0, rd}, 34'hFFFF);
    u_sta.frame(2'h3, pad, dv, 16'h0, rd);
    check("mdio_read", {18'h0, rd}, 34'h1);
    results;
  end
endmodule
bind tmc_top tmc_top_chk u_chk(.i_clk(i_clk), .i_nrst(i_nrst),
  .i_coding_select(i_coding_select),
  .i_direction_config_lo(i_direction_config_lo),
  .i_direction_config_hi(i_direction_config_hi),
  .i_standby_en(i_standby_en), .i_serial_loopback_en(i_serial_loopback_en),
  .i_pattern_test_en(i_pattern_test_en),
  .i_lane_sync_select(i_lane_sync_select),
  .i_buffer_reset_n(i_buffer_reset_n), .o_encoder_en(o_encoder_en),
  .o_decoder_en(o_decoder_en), .o_tx_en(o_tx_en), .o_rx_en(o_rx_en),
  .o_repeater_en(o_repeater_en), .o_low_power(o_low_power),
  .o_loopback_en(o_loopback_en), .o_pattern_gen_en(o_pattern_gen_en),
  .o_pattern_chk_en(o_pattern_chk_en),
  .o_lane_clk_from_a(o_lane_clk_from_a), .o_xgxs_mode(o_xgxs_mode),
  .o_buffer_recenter(o_buffer_recenter), .o_mdio_out(o_mdio_out),
  .o_mdio_oe(o_mdio_oe));
`default_nettype wire
